//--- lsvc_host_model.sv
// Host side of the register port: write and read cycles.
// Assumes callers start a task just after a rising clock edge.
`timescale 1ns/100ps
module lsvc_host_model (
  input wire logic clock,
  output logic [7:0] regAddr,
  output logic [31:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [31:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // Idle lines show inverted values so stale data is never mistaken for valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clock);
    d = regRdData;
  endtask
  // Pump enable is never sent with external supply; no display clock or power pins here
endmodule

//--- lsvc_pkg.sv
// Package for the LCD panel supply voltage control block.
// Assumes a single 100 MHz clock domain and a plain register port.
package lsvc_pkg;

  // ************************************************************
  // Register map (byte offsets, one word each)
  // ************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] VPROG_OFS = 8'h04;
  localparam logic [7:0] MUX_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] TARGET_OFS = 8'h10;

  // ************************************************************
  // Field positions of the control word
  // ************************************************************
  localparam int PUMP_EN_BIT = 0;
  localparam int PUMP_MUL_BIT = 1;
  localparam int COMP_EN_BIT = 2;
  localparam int EXT_SUPPLY_BIT = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic RST_PUMP_EN = 1'b0;
  localparam logic RST_PUMP_MUL = 1'b0;
  localparam logic RST_COMP_EN = 1'b1;
  localparam logic RST_EXT_SUPPLY = 1'b0;
  localparam logic [7:0] RST_VPROG = 8'h00;
  localparam logic [2:0] RST_MUX = 3'h0;

  // ************************************************************
  // Code limits and segment counts
  // ************************************************************
  localparam logic [7:0] CODE_MAX = 8'hFF;
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [5:0] SEG_NORMAL = 6'h2C;
  localparam logic [5:0] SEG_SIX = 6'h2E;

  // Multiplex settings
  typedef enum logic [2:0] {
    LSVC_MUX_STATIC = 3'b000,
    LSVC_MUX_TWO = 3'b001,
    LSVC_MUX_FOUR = 3'b010,
    LSVC_MUX_SIX = 3'b011,
    LSVC_MUX_EIGHT = 3'b100
  } lsvc_mux_e;

  typedef struct packed {
    logic extSupply;
    logic compEnable;
    logic pumpMultiplierSelect;
    logic pumpEnableBit;
  } lsvc_ctrl_s;

  typedef struct packed {
    logic [3:0] backplaneCount;
    logic [5:0] segmentCount;
    logic [8:0] elementCount;
  } lsvc_geom_s;

endpackage

//--- lsvc_supply_ctrl.sv
// LCD panel supply voltage control: target code, pump gating, geometry.
// Assumes a host drives the register port synchronously on clock.
//
// Function
// [R01] Host keeps display clock running while the display output is enabled.
// [R02] Host disables display before stopping the display clock.
// [R03] Host completes power-down sequence before removing device supplies.
// [R04] Support static,2,4,6,8 backplanes; 44 segments, 46 in six-backplane mode.
// [R05] Host never sets pump enable while supply is external.
// [R06] External supply: no temperature compensation even when enabled.
// [R07] External supply: programmed code writes stored but do not affect supply.
// [R08] Pump on/off follows enable bit; multiplier follows select bit.
// [R09] Target supply is programmed code plus temperature offset.
// [R10] Programmed code is unsigned; voltage equals code times 0.03 plus 3.
// [R11] Temperature offset code is two's complement, zero at reference temperature.
// [R12] Reset leaves pump off, supply generation off, compensation on.
// [R13] Offset is sign-extended, added, and saturated at code limits.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
module lsvc_supply_ctrl (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic [7:0] tempOffsetCode,
  output logic pumpOn,
  output logic pumpMultiplier,
  output logic [7:0] supplyTargetCode,
  output logic supplyTargetValid,
  output logic [3:0] backplaneCount,
  output logic [5:0] segmentCount,
  output logic [8:0] elementCount
);

  // ************************************************************
  // Registers
  // ************************************************************
  lsvc_pkg::lsvc_ctrl_s ctrl_reg;
  logic [7:0] vprog_reg;
  lsvc_pkg::lsvc_mux_e mux_reg;
  lsvc_pkg::lsvc_mux_e muxNext;
  logic [31:0] rd_reg;
  logic [31:0] rdNext;
  logic [7:0] target_reg;
  logic [7:0] targetNext;
  lsvc_pkg::lsvc_geom_s geom_reg;
  lsvc_pkg::lsvc_geom_s geomNext;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire hitCtrl = regAddr == lsvc_pkg::CTRL_OFS;
  wire hitVprog = regAddr == lsvc_pkg::VPROG_OFS;
  wire hitMux = regAddr == lsvc_pkg::MUX_OFS;
  wire hitStatus = regAddr == lsvc_pkg::STATUS_OFS;
  wire hitTarget = regAddr == lsvc_pkg::TARGET_OFS;
  wire [2:0] muxField = regWrData[2:0];
  // Undefined multiplex codes are refused so the geometry stays legal
  wire muxLegal = muxField <= 3'(lsvc_pkg::LSVC_MUX_EIGHT);

  // ************************************************************
  // Target computation
  // ************************************************************
  // Offset only applies with internal generation and compensation on
  wire useOffset = ctrl_reg.compEnable & ~ctrl_reg.extSupply; // [R06]
  wire [7:0] offsetUsed = useOffset ? tempOffsetCode : 8'h00; // [R11]
  // Ten-bit signed sum keeps the carry and the sign apart
  wire signed [9:0] sum = $signed({2'b00, vprog_reg}) + $signed({{2{offsetUsed[7]}}, offsetUsed}); // [R09] [R13]

  always_comb begin
    if (sum < 10'sd0) begin
      targetNext = lsvc_pkg::CODE_MIN; // [R13]
    end else if (sum > $signed({2'b00, lsvc_pkg::CODE_MAX})) begin
      targetNext = lsvc_pkg::CODE_MAX; // [R13]
    end else begin
      targetNext = sum[7:0]; // [R10]
    end
  end

  // ************************************************************
  // Display geometry per multiplex setting
  // ************************************************************
  always_comb begin
    geomNext.segmentCount = lsvc_pkg::SEG_NORMAL; // [R04]
    unique case (mux_reg)
      lsvc_pkg::LSVC_MUX_STATIC: begin
        geomNext.backplaneCount = 4'h1;
      end
      lsvc_pkg::LSVC_MUX_TWO: begin
        geomNext.backplaneCount = 4'h2;
      end
      lsvc_pkg::LSVC_MUX_FOUR: begin
        geomNext.backplaneCount = 4'h4;
      end
      lsvc_pkg::LSVC_MUX_SIX: begin
        geomNext.backplaneCount = 4'h6;
        geomNext.segmentCount = lsvc_pkg::SEG_SIX; // [R04]
      end
      lsvc_pkg::LSVC_MUX_EIGHT: begin
        geomNext.backplaneCount = 4'h8;
      end
      default: begin
        geomNext.backplaneCount = 4'h8;
      end
    endcase
    // Operands widened first so the product of eight and forty-four keeps all nine bits
    geomNext.elementCount = 9'(geomNext.backplaneCount) * 9'(geomNext.segmentCount); // [R04]
  end

  assign muxNext = lsvc_pkg::lsvc_mux_e'(muxField);

  // ************************************************************
  // Read mux
  // ************************************************************
  always_comb begin
    rdNext = 32'h0000_0000;
    if (hitCtrl) begin
      rdNext = {28'h000_0000, ctrl_reg};
    end else if (hitVprog) begin
      rdNext = {24'h00_0000, vprog_reg};
    end else if (hitMux) begin
      rdNext = {29'h0000_0000, mux_reg};
    end else if (hitStatus) begin
      rdNext = {5'h00, geom_reg, 6'h00, pumpMultiplier, pumpOn};
    end else if (hitTarget) begin
      rdNext = {23'h00_0000, supplyTargetValid, target_reg};
    end
  end

  // ************************************************************
  // Register updates
  // ************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg.pumpEnableBit <= lsvc_pkg::RST_PUMP_EN; // [R12]
      ctrl_reg.pumpMultiplierSelect <= lsvc_pkg::RST_PUMP_MUL;
      ctrl_reg.compEnable <= lsvc_pkg::RST_COMP_EN; // [R12]
      ctrl_reg.extSupply <= lsvc_pkg::RST_EXT_SUPPLY;
    end else if (regWrite && hitCtrl) begin
      ctrl_reg.pumpEnableBit <= regWrData[lsvc_pkg::PUMP_EN_BIT];
      ctrl_reg.pumpMultiplierSelect <= regWrData[lsvc_pkg::PUMP_MUL_BIT];
      ctrl_reg.compEnable <= regWrData[lsvc_pkg::COMP_EN_BIT];
      ctrl_reg.extSupply <= regWrData[lsvc_pkg::EXT_SUPPLY_BIT];
    end
  end

  // Stored even with external supply; the target code still follows it but supplyTargetValid stays low then
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vprog_reg <= lsvc_pkg::RST_VPROG;
    end else if (regWrite && hitVprog) begin
      vprog_reg <= regWrData[7:0]; // [R07]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mux_reg <= lsvc_pkg::lsvc_mux_e'(lsvc_pkg::RST_MUX);
    end else if (regWrite && hitMux && muxLegal) begin
      mux_reg <= muxNext; // [R04]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_reg <= 32'h0000_0000;
      target_reg <= lsvc_pkg::CODE_MIN;
      geom_reg <= '0;
      pumpOn <= 1'b0;
      pumpMultiplier <= 1'b0;
      supplyTargetValid <= 1'b0;
    end else begin
      rd_reg <= regRead ? rdNext : 32'h0000_0000;
      target_reg <= targetNext; // [R09]
      geom_reg <= geomNext;
      // Pump stays off with external supply as a guard against host misuse
      pumpOn <= ctrl_reg.pumpEnableBit & ~ctrl_reg.extSupply; // [R08] [R05]
      pumpMultiplier <= ctrl_reg.pumpMultiplierSelect; // [R08]
      supplyTargetValid <= ctrl_reg.pumpEnableBit & ~ctrl_reg.extSupply; // [R07]
    end
  end

  assign regRdData = rd_reg;
  assign supplyTargetCode = target_reg;
  assign backplaneCount = geom_reg.backplaneCount;
  assign segmentCount = geom_reg.segmentCount;
  assign elementCount = geom_reg.elementCount;

endmodule

//--- lsvc_supply_ctrl_monitor.sv
// Port checker for the panel supply control block.
// Assumes a bind onto lsvc_supply_ctrl in one clock domain.
`timescale 1ns/100ps
module lsvc_supply_ctrl_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] tempOffsetCode,
  input wire logic pumpOn,
  input wire logic pumpMultiplier,
  input wire logic [7:0] supplyTargetCode,
  input wire logic supplyTargetValid,
  input wire logic [3:0] backplaneCount,
  input wire logic [5:0] segmentCount,
  input wire logic [8:0] elementCount
);
  // ********
  // Port relations
  // ********
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_valid_pump: assert property (supplyTargetValid == pumpOn)
    else $error("valid flag and pump state differ");
  a_seg_count: assert property (backplaneCount == 4'h0 || segmentCount == (backplaneCount == 4'h6 ? 6'h2E : 6'h2C))
    else $error("segment count wrong");
  a_elem_product: assert property (elementCount == {5'h00, backplaneCount} * {3'h0, segmentCount})
    else $error("element count wrong");
  a_bp_set: assert property ($past(nrst) |-> backplaneCount inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
    else $error("backplane count illegal");
  a_reset_pump_off: assert property ($rose(nrst) |-> !pumpOn ##1 !pumpOn)
    else $error("pump on after reset");
  // Target may only move when the offset input moved or a register write landed
  a_target_hold: assert property ($past(nrst) && !$past(regWrite) && $stable(tempOffsetCode) |=> $stable(supplyTargetCode))
    else $error("target moved without cause");
  a_ctrl_cause: assert property (($changed(pumpOn) || $changed(pumpMultiplier)) && $past(nrst, 2) |->
    $past(regWrite, 2) && $past(regAddr, 2) == lsvc_pkg::CTRL_OFS)
    else $error("pump outputs moved without control write");
  a_geom_cause: assert property ($changed(backplaneCount) && $past(nrst, 2) |->
    $past(regWrite, 2) && $past(regAddr, 2) == lsvc_pkg::MUX_OFS)
    else $error("geometry moved without mux write");
endmodule
bind lsvc_supply_ctrl lsvc_supply_ctrl_monitor i_lsvc_supply_ctrl_monitor (.clock(clock), .nrst(nrst),
  .regAddr(regAddr), .regWrite(regWrite), .tempOffsetCode(tempOffsetCode), .pumpOn(pumpOn),
  .pumpMultiplier(pumpMultiplier), .supplyTargetCode(supplyTargetCode), .supplyTargetValid(supplyTargetValid),
  .backplaneCount(backplaneCount), .segmentCount(segmentCount), .elementCount(elementCount));

//--- test_lsvc_supply_ctrl.sv
// Self-checking bench for the panel supply control block.
// Assumes the host model and the bound port checker.
`timescale 1ns/100ps
module test_lsvc_supply_ctrl;
  logic clock, nrst, regWrite, regRead, pumpOn, pumpMultiplier, supplyTargetValid;
  logic [7:0] regAddr, tempOffsetCode, supplyTargetCode;
  logic [31:0] regWrData, regRdData, rdv;
  logic [3:0] backplaneCount;
  logic [5:0] segmentCount;
  logic [8:0] elementCount;
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] vp [6] = '{8'h80, 8'h80, 8'hFE, 8'h02, 8'h40, 8'h80};
  logic [7:0] tp [6] = '{8'h05, 8'hFB, 8'h05, 8'hF0, 8'h00, 8'h10};
  logic [7:0] ex [6] = '{8'h85, 8'h7B, 8'hFF, 8'h00, 8'h40, 8'h80};
  logic [3:0] bp [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
  lsvc_supply_ctrl i_lsvc_supply_ctrl (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .tempOffsetCode(tempOffsetCode),
    .pumpOn(pumpOn), .pumpMultiplier(pumpMultiplier), .supplyTargetCode(supplyTargetCode),
    .supplyTargetValid(supplyTargetValid), .backplaneCount(backplaneCount), .segmentCount(segmentCount),
    .elementCount(elementCount));
  lsvc_host_model i_lsvc_host_model (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    i_lsvc_host_model.rd(a, rdv);
    chk(rdv, exp);
  endtask
  function automatic logic [31:0] geo(input logic [3:0] b, input logic [1:0] p);
    logic [5:0] s;
    s = (b == 4'h6) ? 6'h2E : 6'h2C;
    return {5'h00, b, s, {5'h00, b} * {3'h0, s}, 6'h00, p};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Watchdog: the whole sequence needs far fewer cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    results();
  end
  initial begin
    nrst = 1'b0;
    tempOffsetCode = 8'h00;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdc(lsvc_pkg::CTRL_OFS, 32'h4);
    rdc(lsvc_pkg::STATUS_OFS, geo(4'h1, 2'h0));
    for (int i = 0; i < 5; i++) begin
      i_lsvc_host_model.wr(lsvc_pkg::MUX_OFS, 32'(i));
      rdc(lsvc_pkg::STATUS_OFS, geo(bp[i], 2'h0));
    end
    i_lsvc_host_model.wr(lsvc_pkg::MUX_OFS, 32'h5);
    rdc(lsvc_pkg::STATUS_OFS, geo(4'h8, 2'h0));
    chk({23'h0, elementCount}, 32'h160);
    // Last entry runs with compensation off, so the offset must vanish
    for (int i = 0; i < 6; i++) begin
      tempOffsetCode <= tp[i];
      i_lsvc_host_model.wr(lsvc_pkg::VPROG_OFS, {24'h0, vp[i]});
      i_lsvc_host_model.wr(lsvc_pkg::CTRL_OFS, (i == 5) ? 32'h1 : 32'h5);
      rdc(lsvc_pkg::TARGET_OFS, {23'h0, 1'b1, ex[i]});
      chk({24'h0, supplyTargetCode}, {24'h0, ex[i]});
    end
    i_lsvc_host_model.wr(lsvc_pkg::CTRL_OFS, 32'h3);
    rdc(lsvc_pkg::STATUS_OFS, geo(4'h8, 2'h3));
    i_lsvc_host_model.wr(lsvc_pkg::CTRL_OFS, 32'hC);
    i_lsvc_host_model.wr(lsvc_pkg::VPROG_OFS, 32'h33);
    rdc(lsvc_pkg::VPROG_OFS, 32'h33);
    rdc(lsvc_pkg::TARGET_OFS, 32'h33);
    chk({30'h0, pumpOn, pumpMultiplier}, 32'h0);
    i_lsvc_host_model.wr(8'h14, 32'hF);
    rdc(8'h14, 32'h0);
    rdc(lsvc_pkg::CTRL_OFS, 32'hC);
    nrst <= 1'b0;
    @(posedge clock);
    chk({26'h0, pumpOn, supplyTargetValid, backplaneCount}, 32'h0);
    nrst <= 1'b1;
    @(posedge clock);
    rdc(lsvc_pkg::CTRL_OFS, 32'h4);
    results();
  end
endmodule
